/* File: verilog/pasc_defs.svh */
/*
 * Register offsets, field positions and reset values of the PWM
 * auto-shutdown controller.
 * Assumes an 8-bit APB byte address with one aligned 32-bit word per
 * register.
 */
`ifndef PASC_DEFS_SVH
`define PASC_DEFS_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define PASC_ADDR_CTRL      8'h00
`define PASC_ADDR_CFG       8'h04
`define PASC_ADDR_ISTAT     8'h08
`define PASC_ADDR_IMASK     8'h0C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PASC_CFG_RESTART    0
`define PASC_CFG_COMPARATOR_TWO_SYNC_ENABLE     1
`define PASC_IRQ_SHUT       0
`define PASC_IRQ_RESUME     1
`define PASC_CTRL_STATUS    7
`define PASC_SEL_OFF        3'h0
`define PASC_PIN_A          0
`define PASC_PIN_B          1
`define PASC_PIN_C          2
`define PASC_PIN_D          3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PASC_CTRL_RESET     8'h00
`define PASC_CFG_RESET      2'h0
`define PASC_IRQ_RESET      2'h0
`define PASC_WORD_ZERO      32'h0000_0000

`endif

/* File: verilog/pasc_pkg.sv */
/*
 * Types shared by the PWM auto-shutdown controller files.
 * Assumes the constants header is compiled alongside.
 */
package pasc_pkg;

	// ------------------------------------------------------------------
	// Bus carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} pasc_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} pasc_apb_rsp_t;

	// ------------------------------------------------------------------
	// Control register layout, bit 7 down to bit 0
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       shutdown_event_status;
		logic [2:0] shutdown_source_select;
		logic [1:0] pair_ac_shutdown_state;
		logic [1:0] pair_bd_shutdown_state;
	} pasc_ctrl_t;

	// Output hold sequence.
	typedef enum logic [2:0] {
		PASC_RUN  = 3'b001,
		PASC_SHUT = 3'b010,
		PASC_WAIT = 3'b100
	} pasc_state_t;

	// Pin group: four outputs a, b, c, d with enables.
	typedef struct packed {
		logic [3:0] level;
		logic [3:0] oe;
	} pasc_pins_t;

endpackage

/* File: verilog/pasc_sync.sv */
/*
 * Two-stage synchroniser for a group of asynchronous level inputs.
 * Assumes the inputs are levels that stay long enough to be seen.
 */
module pasc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	import pasc_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} pasc_sync_t;

	pasc_sync_t r;
	pasc_sync_t next_r;

	// The first stage feeds only the second one.
	always_comb
	begin
		next_r.meta = d;
		next_r.stable = r.meta;
	end

	// Both stages clear to zero under reset.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			r <= '0;
		else
			r <= next_r;
	end

	assign q = r.stable;
endmodule

/* File: verilog/pasc_c2_delay.sv */
/*
 * Optional timer-one resampling of the second comparator output.
 * Assumes timer_one_tick is a one-cycle pulse on clk and cmp_in is
 * already synchronised to clk.
 */
module pasc_c2_delay (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic sync_enable,
	input  wire logic timer_one_tick,
	input  wire logic cmp_in,
	output logic      cmp_out
);
	import pasc_pkg::*;

	typedef struct packed {
		logic held;
	} pasc_c2_t;

	pasc_c2_t r;
	pasc_c2_t next_r;

	// The comparator level is only taken on a timer tick, so a trip
	// waits for the next tick; this is the cost of noise immunity.
	always_comb
	begin
		next_r = r;
		if (timer_one_tick)
			next_r.held = cmp_in;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			r <= '0;
		else
			r <= next_r;
	end

	assign cmp_out = sync_enable ? r.held : cmp_in;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	c2_hold_stable_a: assert property (
		!timer_one_tick |=> $stable(r.held))
		else $error("Delayed comparator changed without a tick.");
endmodule

/* File: verilog/pasc_top.sv */
/*
 * PWM auto-shutdown controller with APB register access.
 * Assumes the PWM waveforms, period start pulse, pin enables and timer
 * tick come from logic on clk; comparator and fault pin levels are
 * asynchronous and are synchronised here.
 */
// Contract
// - Control bit 7 reads one while a shutdown event is latched, else zero.
// - Bits 6 to 4 select the sources, and zero disables all sources.
// - Codes 001, 010, 011 trip on comparator one, two, or either high.
// - Code 100 trips on a low fault pin; 101 to 111 add comparators.
// - Pins a and c shut to low on 00, high on 01, float on 1x.
// - Pins b and d shut to low on 00, high on 01, float on 1x.
// - Shutdown is level based and lasts while the source is active.
// - Writes to the status bit do nothing while a source is active.
// - After the status clears, output resumes at the next period.
// - Writing one to the status bit itself forces a shutdown.
// - The status stays set until firmware or auto restart clears it.
// - Enabled pins take their shutdown state without waiting.
// - With auto restart, hardware clears status once the source ends.
module pasc_top (
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire pasc_pkg::pasc_apb_req_t apb_req,
	output pasc_pkg::pasc_apb_rsp_t  apb_rsp,
	input  wire logic                comparator_one,
	input  wire logic                comparator_two,
	input  wire logic                fault_pin_n,
	input  wire logic                timer_one_tick,
	input  wire logic                period_start,
	input  wire logic [3:0]          pwm_wave,
	input  wire logic [3:0]          pin_enable,
	output logic                     pwm_out_a,
	output logic                     pwm_out_b,
	output logic                     pwm_out_c,
	output logic                     pwm_out_d,
	output logic                     pwm_oe_a,
	output logic                     pwm_oe_b,
	output logic                     pwm_oe_c,
	output logic                     pwm_oe_d,
	output logic                     irq
);
	import pasc_pkg::*;
	`include "pasc_defs.svh"

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		pasc_ctrl_t    ctrl;
		logic [1:0]    cfg;
		logic [1:0]    istat;
		logic [1:0]    imask;
		pasc_state_t   fsm;
		pasc_apb_rsp_t rsp;
		pasc_pins_t    pins;
		logic          irq;
	} pasc_regs_t;

	pasc_regs_t r;
	pasc_regs_t next_r;

	logic [2:0] sync_in;
	logic [2:0] sync_out;
	logic       cmp1_s;
	logic       cmp2_s;
	logic       cmp2_eff;
	logic       fault_low;
	logic       cond;
	logic       access;
	logic       wr_ctrl;
	logic       fw_set;
	logic       fw_clr;
	logic       auto_clr;
	logic       hold;
	logic [1:0] pair_state;
	logic [31:0] rdata;
	logic       unmapped;

	// ------------------------------------------------------------------
	// Input conditioning
	// ------------------------------------------------------------------
	// Pin levels are asynchronous, so all three pass two flip-flops.
	assign sync_in = {fault_pin_n, comparator_two, comparator_one};

	pasc_sync #(
		.WIDTH (3)
	) u_sync (
		.clk    (clk),
		.resetn (resetn),
		.d      (sync_in),
		.q      (sync_out)
	);

	assign cmp1_s = sync_out[0];
	assign cmp2_s = sync_out[1];
	assign fault_low = !sync_out[2];

	pasc_c2_delay u_c2_delay (
		.clk            (clk),
		.resetn         (resetn),
		.sync_enable    (r.cfg[`PASC_CFG_COMPARATOR_TWO_SYNC_ENABLE]),
		.timer_one_tick (timer_one_tick),
		.cmp_in         (cmp2_s),
		.cmp_out        (cmp2_eff)
	);

	// Each select bit arms one source; code zero arms none.
	assign cond = (r.ctrl.shutdown_source_select[0] && cmp1_s)
		|| (r.ctrl.shutdown_source_select[1] && cmp2_eff)
		|| (r.ctrl.shutdown_source_select[2] && fault_low);

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	// A transfer completes in the access cycle where pready is high.
	assign access = apb_req.psel && apb_req.penable && r.rsp.pready;
	assign wr_ctrl = access && apb_req.pwrite
		&& (apb_req.paddr == `PASC_ADDR_CTRL);
	assign fw_set = wr_ctrl && apb_req.pwdata[`PASC_CTRL_STATUS];
	assign fw_clr = wr_ctrl && !apb_req.pwdata[`PASC_CTRL_STATUS];
	assign auto_clr = r.cfg[`PASC_CFG_RESTART];

	// Read data is prepared while pready is still low.
	always_comb
	begin
		rdata = `PASC_WORD_ZERO;
		unmapped = 1'b0;
		case (apb_req.paddr)
			`PASC_ADDR_CTRL:  rdata[7:0] = r.ctrl;
			`PASC_ADDR_CFG:   rdata[1:0] = r.cfg;
			`PASC_ADDR_ISTAT: rdata[1:0] = r.istat;
			`PASC_ADDR_IMASK: rdata[1:0] = r.imask;
			default:          unmapped = 1'b1;
		endcase
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		next_r = r;
		hold = 1'b0;
		pair_state = 2'h0;

		// One wait state: pready is set at the end of the first access cycle and is high in the second.
		next_r.rsp.pready = apb_req.psel && apb_req.penable
			&& !r.rsp.pready;
		if (next_r.rsp.pready)
		begin
			next_r.rsp.prdata = apb_req.pwrite ? `PASC_WORD_ZERO : rdata;
			next_r.rsp.pslverr = unmapped;
		end

		// Configuration writes; the status bit is handled below.
		if (wr_ctrl)
		begin
			next_r.ctrl.shutdown_source_select = apb_req.pwdata[6:4];
			next_r.ctrl.pair_ac_shutdown_state = apb_req.pwdata[3:2];
			next_r.ctrl.pair_bd_shutdown_state = apb_req.pwdata[1:0];
		end
		if (access && apb_req.pwrite
			&& apb_req.paddr == `PASC_ADDR_CFG)
			next_r.cfg = apb_req.pwdata[1:0];
		if (access && apb_req.pwrite
			&& apb_req.paddr == `PASC_ADDR_IMASK)
			next_r.imask = apb_req.pwdata[1:0];

		// A live source or a firmware set wins over any clear, so a
		// clear write during a fault is simply lost.
		if (cond || fw_set)
			next_r.ctrl.shutdown_event_status = 1'b1;
		else if (r.ctrl.shutdown_event_status && (fw_clr || auto_clr))
			next_r.ctrl.shutdown_event_status = 1'b0;

		// Outputs stay held after the clear until a period boundary.
		case (r.fsm)
			PASC_RUN:
			begin
				if (next_r.ctrl.shutdown_event_status)
					next_r.fsm = PASC_SHUT;
			end
			PASC_SHUT:
			begin
				if (!next_r.ctrl.shutdown_event_status)
					next_r.fsm = PASC_WAIT;
			end
			PASC_WAIT:
			begin
				if (next_r.ctrl.shutdown_event_status)
					next_r.fsm = PASC_SHUT;
				else if (period_start)
					next_r.fsm = PASC_RUN;
			end
			default:
				next_r.fsm = PASC_SHUT;
		endcase

		// Event flags: set wins over a write-one-to-clear.
		if (access && apb_req.pwrite
			&& apb_req.paddr == `PASC_ADDR_ISTAT)
			next_r.istat = r.istat & ~apb_req.pwdata[1:0];
		if (r.fsm != PASC_SHUT && next_r.fsm == PASC_SHUT)
			next_r.istat[`PASC_IRQ_SHUT] = 1'b1;
		if (r.fsm == PASC_WAIT && next_r.fsm == PASC_RUN)
			next_r.istat[`PASC_IRQ_RESUME] = 1'b1;
		next_r.irq = |(next_r.istat & next_r.imask);

		// Pins follow the next state, so they change at the very edge
		// the status sets rather than a cycle later.
		hold = (next_r.fsm != PASC_RUN);
		for (int i = 0; i < 4; i++)
		begin
			if (i == `PASC_PIN_A || i == `PASC_PIN_C)
				pair_state = next_r.ctrl.pair_ac_shutdown_state;
			else
				pair_state = next_r.ctrl.pair_bd_shutdown_state;
			if (hold && pin_enable[i])
			begin
				next_r.pins.oe[i] = !pair_state[1];
				next_r.pins.level[i] = pair_state[1] ? 1'b0 : pair_state[0];
			end
			else
			begin
				next_r.pins.oe[i] = pin_enable[i];
				next_r.pins.level[i] = pwm_wave[i];
			end
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			r <= '0;
			r.ctrl <= `PASC_CTRL_RESET;
			r.cfg <= `PASC_CFG_RESET;
			r.istat <= `PASC_IRQ_RESET;
			r.imask <= `PASC_IRQ_RESET;
			r.fsm <= PASC_RUN;
		end
		else
			r <= next_r;
	end

	// Every output is a flip-flop of the state record.
	assign apb_rsp = r.rsp;
	assign pwm_out_a = r.pins.level[`PASC_PIN_A];
	assign pwm_out_b = r.pins.level[`PASC_PIN_B];
	assign pwm_out_c = r.pins.level[`PASC_PIN_C];
	assign pwm_out_d = r.pins.level[`PASC_PIN_D];
	assign pwm_oe_a = r.pins.oe[`PASC_PIN_A];
	assign pwm_oe_b = r.pins.oe[`PASC_PIN_B];
	assign pwm_oe_c = r.pins.oe[`PASC_PIN_C];
	assign pwm_oe_d = r.pins.oe[`PASC_PIN_D];
	assign irq = r.irq;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	status_on_cond_a: assert property (
		cond |=> r.ctrl.shutdown_event_status)
		else $error("Status not set in the cycle the source was seen.");

	status_level_a: assert property (
		r.ctrl.shutdown_event_status |-> r.fsm == PASC_SHUT)
		else $error("Status set while outputs are not shut down.");

	select_off_a: assert property (
		(r.ctrl.shutdown_source_select == `PASC_SEL_OFF
			&& !fw_set && !r.ctrl.shutdown_event_status)
		|=> !r.ctrl.shutdown_event_status)
		else $error("Shutdown with all sources disabled.");

	cmp_one_trip_a: assert property (
		(r.ctrl.shutdown_source_select == 3'h1 && cmp1_s)
		|=> r.ctrl.shutdown_event_status)
		else $error("Comparator one did not trip the shutdown.");

	fault_pin_trip_a: assert property (
		(r.ctrl.shutdown_source_select[2] && fault_low)
		|=> r.ctrl.shutdown_event_status)
		else $error("Low fault pin did not trip the shutdown.");

	pair_ac_state_a: assert property (
		(r.fsm != PASC_RUN && $past(pin_enable[`PASC_PIN_C]))
		|-> (r.pins.oe[`PASC_PIN_C]
			== !r.ctrl.pair_ac_shutdown_state[1])
		&& (r.pins.oe[`PASC_PIN_C] == 1'b0
			|| r.pins.level[`PASC_PIN_C]
			== r.ctrl.pair_ac_shutdown_state[0]))
		else $error("Pin c not in its programmed shutdown state.");

	pair_bd_state_a: assert property (
		(r.fsm != PASC_RUN && $past(pin_enable[`PASC_PIN_B]))
		|-> (r.pins.oe[`PASC_PIN_B]
			== !r.ctrl.pair_bd_shutdown_state[1])
		&& (r.pins.oe[`PASC_PIN_B] == 1'b0
			|| r.pins.level[`PASC_PIN_B]
			== r.ctrl.pair_bd_shutdown_state[0]))
		else $error("Pin b not in its programmed shutdown state.");

	level_persist_a: assert property (
		cond [*2] |-> r.ctrl.shutdown_event_status
			##1 r.ctrl.shutdown_event_status)
		else $error("Shutdown released while the source is active.");

	clear_blocked_a: assert property (
		(cond && fw_clr) |=> r.ctrl.shutdown_event_status)
		else $error("Status write took effect during a live fault.");

	resume_period_a: assert property (
		(r.fsm == PASC_WAIT && !period_start)
		|=> r.fsm != PASC_RUN)
		else $error("Output resumed before a period start.");

	firmware_set_a: assert property (
		fw_set |=> r.ctrl.shutdown_event_status && r.fsm == PASC_SHUT)
		else $error("Firmware set did not force a shutdown.");

	status_sticky_a: assert property (
		(r.ctrl.shutdown_event_status && !wr_ctrl && !auto_clr)
		|=> r.ctrl.shutdown_event_status)
		else $error("Status cleared with no clear request.");

	pins_same_edge_a: assert property (
		($rose(r.ctrl.shutdown_event_status)
			&& $past(pin_enable[`PASC_PIN_A])
			&& r.ctrl.pair_ac_shutdown_state == 2'h1)
		|-> r.pins.level[`PASC_PIN_A] && r.pins.oe[`PASC_PIN_A])
		else $error("Pin a lagged the status bit.");

	auto_restart_a: assert property (
		(r.ctrl.shutdown_event_status && auto_clr && !cond && !fw_set)
		|=> !r.ctrl.shutdown_event_status && r.fsm != PASC_SHUT)
		else $error("Auto restart did not clear the status.");
endmodule

/* File: testbench/pasc_src_model.sv */
/*
 * Far-side model: two comparator outputs and the active-low fault pin.
 * Assumes the bench changes the source requests right after a clock edge.
 */
module pasc_src_model (
	input  wire logic trip_one,
	input  wire logic trip_two,
	input  wire logic fault_on,
	output logic      comparator_one,
	output logic      comparator_two,
	output logic      fault_pin_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// Comparators drive push-pull levels.
	assign comparator_one = trip_one;
	assign comparator_two = trip_two;
	// The fault pin idles high on its pull-up and is pulled low on a fault.
	assign fault_pin_n = !fault_on;
endmodule

/* File: testbench/tb_top.sv */
/*
 * Self-checking bench for the PWM auto-shutdown controller.
 * Assumes the design files and the source model are compiled first.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pasc_pkg::*;

	logic          clk, resetn, tick, pstart, irq, err;
	logic          src_one, src_two, src_flt, cmp_one, cmp_two, flt_n;
	pasc_apb_req_t req;
	pasc_apb_rsp_t rsp;
	logic [3:0]    wave, en, lvl, oe;
	logic [15:0]   seed;
	logic [31:0]   rd;
	logic [7:0]    m_ctrl;
	bit            m_trip;
	int            fails, num_checks;

	pasc_top pasc_top_inst (.clk(clk), .resetn(resetn), .apb_req(req),
		.apb_rsp(rsp), .comparator_one(cmp_one), .comparator_two(cmp_two),
		.fault_pin_n(flt_n), .timer_one_tick(tick), .period_start(pstart),
		.pwm_wave(wave), .pin_enable(en), .pwm_out_a(lvl[0]),
		.pwm_out_b(lvl[1]), .pwm_out_c(lvl[2]), .pwm_out_d(lvl[3]),
		.pwm_oe_a(oe[0]), .pwm_oe_b(oe[1]), .pwm_oe_c(oe[2]),
		.pwm_oe_d(oe[3]), .irq(irq));
	pasc_src_model pasc_src_model_inst (.trip_one(src_one),
		.trip_two(src_two), .fault_on(src_flt), .comparator_one(cmp_one),
		.comparator_two(cmp_two), .fault_pin_n(flt_n));

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	always #2 clk = ~clk;

	// A hang anywhere ends the run as a failure.
	initial
	begin
		#80000;
		fails++;
		stop_test();
	end

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Pready is taken at the rising edge, where the slave ends the access.
	task automatic apb(input logic wr, input logic [7:0] a, input int d);
		int n;
		@(posedge clk);
		req <= '{1'b1, 1'b0, wr, a, 32'(d)};
		@(posedge clk);
		req.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 20);
		if (rsp.pready !== 1'b1)
		begin
			fails++;
			stop_test();
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input int e);
		apb(1'b0, a, 0);
		chk(what, rd, 32'(e));
	endtask

	task automatic kick(input bit timer);
		@(posedge clk);
		if (timer)
			tick <= 1'b1;
		else
			pstart <= 1'b1;
		@(posedge clk);
		tick <= 1'b0;
		pstart <= 1'b0;
		cyc(1);
	endtask

	// Expected pin drive: safe states on enabled pins while shut down.
	task automatic pins(input bit sh);
		logic [7:0] e;
		logic [1:0] st;
		for (int i = 0; i < 4; i++)
		begin
			st = i[0] ? m_ctrl[1:0] : m_ctrl[3:2];
			e[i + 4] = (sh && en[i]) ? !st[1] : en[i];
			e[i] = (sh && en[i]) ? (!st[1] && st[0]) : wave[i];
		end
		@(negedge clk);
		chk("pins", {24'h0, oe, lvl}, {24'h0, e});
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		clk = 0;
		resetn = 0;
		req = '0;
		{src_one, src_two, src_flt, tick, pstart} = '0;
		{wave, en} = 8'hFF;
		seed = 16'h002B;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		cyc(2);
		for (int a = 0; a < 16; a += 4)
			rdchk("reset", 8'(a), 0);
		apb(1'b0, 8'h10, 0);
		chk("slverr", {31'h0, err}, 32'h1);
		chk("unmapped", rd, 32'h0);
		apb(1'b1, 8'h0C, 3);
		// Every source code against each source on its own.
		for (int s = 0; s < 8; s++)
			for (int k = 0; k < 3; k++)
			begin
				seed = lfsr(seed);
				wave <= seed[3:0];
				en <= seed[7:4];
				m_ctrl = {1'b0, s[2:0], seed[11:8]};
				apb(1'b1, 8'h00, m_ctrl);
				src_one <= (k == 0);
				src_two <= (k == 1);
				src_flt <= (k == 2);
				m_trip = (s[0] && k == 0) || (s[1] && k == 1) || (s[2] && k == 2);
				cyc(4);
				rdchk("status", 8'h00, {m_trip, m_ctrl[6:0]});
				pins(m_trip);
				chk("irq", {31'h0, irq}, 32'(m_trip));
				apb(1'b1, 8'h00, m_ctrl);
				rdchk("clear lost", 8'h00, {m_trip, m_ctrl[6:0]});
				{src_one, src_two, src_flt} <= '0;
				cyc(4);
				rdchk("sticky", 8'h00, {m_trip, m_ctrl[6:0]});
				apb(1'b1, 8'h00, m_ctrl);
				rdchk("cleared", 8'h00, m_ctrl);
				pins(m_trip);
				kick(1'b0);
				pins(1'b0);
				rdchk("istat", 8'h08, {m_trip, m_trip});
				apb(1'b1, 8'h08, 3);
				cyc(2);
				chk("irq clr", {31'h0, irq}, 32'h0);
			end
		// Firmware sets the status bit with no source selected.
		m_ctrl = 8'h0D;
		apb(1'b1, 8'h00, 8'h8D);
		rdchk("fw set", 8'h00, 8'h8D);
		pins(1'b1);
		apb(1'b1, 8'h00, m_ctrl);
		kick(1'b0);
		pins(1'b0);
		// Auto restart with comparator two resampled by the timer.
		apb(1'b1, 8'h04, 3);
		m_ctrl = 8'h21;
		apb(1'b1, 8'h00, m_ctrl);
		src_two <= 1'b1;
		cyc(6);
		rdchk("no tick", 8'h00, 8'h21);
		kick(1'b1);
		cyc(3);
		rdchk("tick", 8'h00, 8'hA1);
		src_two <= 1'b0;
		// The drop must clear the synchroniser before the tick samples it.
		cyc(3);
		kick(1'b1);
		cyc(3);
		rdchk("restart", 8'h00, 8'h21);
		pins(1'b1);
		kick(1'b0);
		pins(1'b0);
		stop_test();
	end
endmodule
